// file: oad_pkg.sv
package oad_pkg;
  localparam int DATA_W = 16;
  localparam int DEFAULT_WORKING_REGISTER_N = 16;
  localparam int WIDX_W = 4;
  localparam int NEAR_W = 13;
  localparam int LIT5_W = 5;
  localparam int LIT10_W = 10;
  localparam logic [WIDX_W-1:0] WORKING_REGISTER_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] PTR_STEP = 16'h0002;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  typedef enum logic [2:0] {
    OAD_DIRECT = 3'h0,
    OAD_INDIRECT = 3'h1,
    OAD_POST_INC = 3'h2,
    OAD_POST_DEC = 3'h3,
    OAD_PRE_INC = 3'h4,
    OAD_PRE_DEC = 3'h5,
    OAD_LIT5 = 3'h6,
    OAD_LIT10 = 3'h7
  } oad_mode_t;

  typedef enum logic [1:0] {
    OAD_CLS_FILE = 2'h0,
    OAD_CLS_THREE = 2'h1,
    OAD_CLS_XFER = 2'h2,
    OAD_CLS_PRODUCT = 2'h3
  } oad_class_t;

  typedef struct packed {
    logic valid;
    oad_class_t cls;
    logic mac_class;
    logic [7:0] mode_allow;
    logic [NEAR_W-1:0] near_addr;
    logic [DATA_W-1:0] full_addr;
    logic to_default_working_register;
    logic [WIDX_W-1:0] base_sel;
    oad_mode_t src_mode;
    logic [WIDX_W-1:0] src_sel;
    logic [LIT10_W-1:0] literal;
    oad_mode_t dst_mode;
    logic [WIDX_W-1:0] dst_sel;
    logic dst_pair;
  } oad_req_t;

  typedef struct packed {
    logic valid;
    logic mode_error;
    logic [DATA_W-1:0] op1;
    logic op2_from_mem;
    logic [DATA_W-1:0] op2_addr;
    logic [DATA_W-1:0] op2_lit;
    logic res_to_mem;
    logic [DATA_W-1:0] res_addr;
    logic [WIDX_W-1:0] res_reg;
    logic res_pair;
  } oad_resp_t;
endpackage

// file: oad_decode.sv
// Functional notes
// [RULE1] direct address from 13-bit near field
// [RULE2] working register zero is default register
// [RULE3] file result to file or default register
// [RULE4] transfer instruction reaches whole data space
// [RULE5] three-operand: op1 function op2 gives op3
// [RULE6] first operand always base working register
// [RULE7] second operand memory-fetched register or literal
// [RULE8] result to working register or memory
// [RULE9] direct, indirect, post, pre, literal modes
// [RULE10] each instruction limited to its modes; mode_allow is checked for the three-operand class only
// [RULE11] multiply-accumulate class uses separate modes
// [RULE12] indirect: pointer contents form effective address
// [RULE13] post-modify: use pointer, then step it; the source pointer is not stepped when the destination mode also modifies
// [RULE14] pre-modify: step pointer, then use it; with a modifying destination the source step is not written back
// [RULE15] near field zero-extended to data address
module oad_decode
  import oad_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire oad_req_t req,
  input wire logic [DEFAULT_WORKING_REGISTER_N*DATA_W-1:0] default_working_register_file,
  output oad_resp_t resp,
  output logic ptr_we,
  output logic [WIDX_W-1:0] ptr_idx,
  output logic [DATA_W-1:0] ptr_value
);

  // ****************************************
  // register read and pointer step
  // ****************************************
  logic [DATA_W-1:0] wr [DEFAULT_WORKING_REGISTER_N];
  genvar gi;
  generate
    for (gi = 0; gi < DEFAULT_WORKING_REGISTER_N; gi++) begin : g_rd
      assign wr[gi] = default_working_register_file[gi*DATA_W +: DATA_W];
    end
  endgenerate

  function automatic logic [DATA_W-1:0] stepped(input oad_mode_t m, input logic [DATA_W-1:0] p);
    logic [DATA_W-1:0] r;
    r = p;
    if (m == OAD_POST_INC || m == OAD_PRE_INC) begin
      r = p + PTR_STEP;
    end else if (m == OAD_POST_DEC || m == OAD_PRE_DEC) begin
      r = p - PTR_STEP;
    end
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] eff_addr(input oad_mode_t m, input logic [DATA_W-1:0] p);
    logic [DATA_W-1:0] r;
    r = p; // RULE12 RULE13
    if (m == OAD_PRE_INC || m == OAD_PRE_DEC) begin
      r = stepped(m, p); // RULE14
    end
    return r;
  endfunction

  function automatic logic is_mod(input oad_mode_t m);
    return m inside {OAD_POST_INC, OAD_POST_DEC, OAD_PRE_INC, OAD_PRE_DEC};
  endfunction

  // ****************************************
  // operand resolution
  // ****************************************
  oad_resp_t next_resp;
  logic next_ptr_we;
  logic [WIDX_W-1:0] next_ptr_idx;
  logic [DATA_W-1:0] next_ptr_value;
  logic src_ok;
  logic dst_ok;

  always_comb begin
    next_resp = '0;
    next_ptr_we = 1'b0;
    next_ptr_idx = '0;
    next_ptr_value = ZERO_WORD;
    src_ok = req.mode_allow[req.src_mode]; // RULE10
    dst_ok = req.mode_allow[req.dst_mode];
    next_resp.valid = req.valid;
    if (req.valid) begin
      case (req.cls)
        OAD_CLS_FILE, OAD_CLS_PRODUCT: begin
          next_resp.op2_from_mem = 1'b1;
          next_resp.op2_addr = {{(DATA_W-NEAR_W){1'b0}}, req.near_addr}; // RULE1 RULE15
          next_resp.op1 = wr[WORKING_REGISTER_ZERO]; // RULE2
          if (req.cls == OAD_CLS_PRODUCT) begin
            next_resp.res_reg = req.dst_sel; // RULE3
            next_resp.res_pair = req.dst_pair;
          end else if (req.to_default_working_register) begin
            next_resp.res_reg = WORKING_REGISTER_ZERO; // RULE3
          end else begin
            next_resp.res_to_mem = 1'b1;
            next_resp.res_addr = {{(DATA_W-NEAR_W){1'b0}}, req.near_addr}; // RULE3
          end
        end
        OAD_CLS_XFER: begin
          next_resp.op2_from_mem = 1'b1;
          next_resp.op2_addr = req.full_addr; // RULE4
          next_resp.res_reg = req.dst_sel;
          next_resp.res_to_mem = ~req.to_default_working_register;
          next_resp.res_addr = req.full_addr;
        end
        OAD_CLS_THREE: begin
          // op3 = op1 <function> op2; function lives in the ALU
          next_resp.op1 = wr[req.base_sel]; // RULE5 RULE6
          next_resp.mode_error = req.mac_class | ~src_ok | ~dst_ok; // RULE10 RULE11
          case (req.src_mode) // RULE7 RULE9
            OAD_LIT5: next_resp.op2_lit = {{(DATA_W-LIT5_W){1'b0}}, req.literal[LIT5_W-1:0]};
            OAD_LIT10: next_resp.op2_lit = {{(DATA_W-LIT10_W){1'b0}}, req.literal};
            OAD_DIRECT: next_resp.op2_lit = wr[req.src_sel];
            default: begin
              next_resp.op2_from_mem = 1'b1;
              next_resp.op2_addr = eff_addr(req.src_mode, wr[req.src_sel]);
            end
          endcase
          case (req.dst_mode) // RULE8
            OAD_DIRECT, OAD_LIT5, OAD_LIT10: next_resp.res_reg = req.dst_sel;
            default: begin
              next_resp.res_to_mem = 1'b1;
              next_resp.res_addr = eff_addr(req.dst_mode, wr[req.dst_sel]);
            end
          endcase
          if (!next_resp.mode_error) begin
            if (is_mod(req.dst_mode)) begin
              next_ptr_we = 1'b1;
              next_ptr_idx = req.dst_sel;
              next_ptr_value = stepped(req.dst_mode, wr[req.dst_sel]); // RULE13 RULE14
            end else if (is_mod(req.src_mode)) begin
              next_ptr_we = 1'b1;
              next_ptr_idx = req.src_sel;
              next_ptr_value = stepped(req.src_mode, wr[req.src_sel]); // RULE13 RULE14
            end
          end
          if (next_resp.mode_error) begin
            next_resp.res_to_mem = 1'b0;
          end
        end
        default: next_resp.mode_error = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp <= '0;
      ptr_we <= 1'b0;
      ptr_idx <= '0;
      ptr_value <= ZERO_WORD;
    end else begin
      resp <= next_resp;
      ptr_we <= next_ptr_we;
      ptr_idx <= next_ptr_idx;
      ptr_value <= next_ptr_value;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_NEAR_ZERO_EXT: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE15
    req.valid && req.cls == OAD_CLS_FILE |=> resp.op2_addr[DATA_W-1:NEAR_W] == '0)
    else $error("near address not zero-extended");
  AST_NEAR_ADDR: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE1
    req.valid && req.cls == OAD_CLS_FILE |=> resp.op2_addr[NEAR_W-1:0] == $past(req.near_addr))
    else $error("near address wrong");
  AST_DEFAULT_WORKING_REGISTER_DEFAULT: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE2
    req.valid && req.cls == OAD_CLS_FILE |=> resp.op1 == $past(wr[WORKING_REGISTER_ZERO]))
    else $error("default register not used");
  AST_FILE_DEST: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE3
    req.valid && req.cls == OAD_CLS_FILE && req.to_default_working_register |=> !resp.res_to_mem && resp.res_reg == '0)
    else $error("file result not to default register");
  AST_XFER_FULL: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE4
    req.valid && req.cls == OAD_CLS_XFER |=> resp.op2_addr == $past(req.full_addr))
    else $error("transfer address truncated");
  AST_BASE_OP: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE6
    req.valid && req.cls == OAD_CLS_THREE |=> resp.op1 == $past(wr[req.base_sel]))
    else $error("first operand not base register");
  AST_LIT5: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE7
    req.valid && req.cls == OAD_CLS_THREE && req.src_mode == OAD_LIT5
    |=> !resp.op2_from_mem && resp.op2_lit[DATA_W-1:LIT5_W] == '0)
    else $error("short literal wrong");
  AST_PRE_EA: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
    req.valid && req.cls == OAD_CLS_THREE && req.src_mode == OAD_PRE_INC
    |=> resp.op2_addr == $past(wr[req.src_sel]) + PTR_STEP)
    else $error("pre-modify address wrong");
  AST_POST_EA: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE13
    req.valid && req.cls == OAD_CLS_THREE && req.src_mode == OAD_POST_DEC && !is_mod(req.dst_mode)
    && !req.mac_class && req.mode_allow[OAD_POST_DEC] && req.mode_allow[req.dst_mode]
    |=> resp.op2_addr == $past(wr[req.src_sel]) && ptr_we && ptr_value == $past(wr[req.src_sel]) - PTR_STEP)
    else $error("post-modify wrong");
  AST_MODE_LIMIT: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE10
    req.valid && req.cls == OAD_CLS_THREE && !req.mode_allow[req.src_mode] |=> resp.mode_error && !ptr_we)
    else $error("illegal mode accepted");
  AST_MAC_SEP: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE11
    req.valid && req.cls == OAD_CLS_THREE && req.mac_class |=> resp.mode_error)
    else $error("mac class accepted here");
  AST_THREE_REG_DEST: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE5
    req.valid && req.cls == OAD_CLS_THREE && req.dst_mode == OAD_DIRECT
    |=> !resp.res_to_mem && resp.res_reg == $past(req.dst_sel))
    else $error("third operand register wrong");
  AST_MEM_DEST: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE8
    req.valid && req.cls == OAD_CLS_THREE && req.dst_mode == OAD_INDIRECT && !req.mac_class
    && req.mode_allow[req.src_mode] && req.mode_allow[req.dst_mode]
    |=> resp.res_to_mem && resp.res_addr == $past(wr[req.dst_sel]))
    else $error("memory result address wrong");
  AST_LIT10: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE9
    req.valid && req.cls == OAD_CLS_THREE && req.src_mode == OAD_LIT10
    |=> !resp.op2_from_mem && resp.op2_lit == {{(DATA_W-LIT10_W){1'b0}}, $past(req.literal)})
    else $error("long literal wrong");
  AST_IND_EA: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE12
    req.valid && req.cls == OAD_CLS_THREE && req.src_mode == OAD_INDIRECT
    |=> resp.op2_from_mem && resp.op2_addr == $past(wr[req.src_sel]))
    else $error("indirect address wrong");
  AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE13
    !req.valid |=> !resp.valid && !ptr_we)
    else $error("output without request");
  AST_REFUSE_NO_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE10
    resp.mode_error |-> !resp.res_to_mem && !ptr_we)
    else $error("refused request still writes");
  AST_PRODUCT_DEST: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE3
    req.valid && req.cls == OAD_CLS_PRODUCT
    |=> !resp.res_to_mem && resp.res_reg == $past(req.dst_sel) && resp.res_pair == $past(req.dst_pair))
    else $error("product destination wrong");
  AST_DST_STEP: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
    req.valid && req.cls == OAD_CLS_THREE && req.dst_mode == OAD_PRE_DEC && !req.mac_class
    && req.mode_allow[req.src_mode] && req.mode_allow[req.dst_mode]
    |=> ptr_we && ptr_idx == $past(req.dst_sel) && resp.res_addr == $past(wr[req.dst_sel]) - PTR_STEP)
    else $error("destination pre-modify wrong");
endmodule

// file: oad_default_working_register_model.sv
module oad_default_working_register_model
  import oad_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ptr_we,
  input wire logic [WIDX_W-1:0] ptr_idx,
  input wire logic [DATA_W-1:0] ptr_value,
  output logic [DEFAULT_WORKING_REGISTER_N*DATA_W-1:0] default_working_register_file
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] regs [DEFAULT_WORKING_REGISTER_N];
  // ***************
  // working registers, pointer step applied one edge after request
  // ***************
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DEFAULT_WORKING_REGISTER_N; i++) begin
        regs[i] <= 16'h1000 + 16'(i) * 16'h0100;
      end
    end else if (ptr_we) begin
      regs[ptr_idx] <= ptr_value;
    end
  end
  always_comb begin
    for (int i = 0; i < DEFAULT_WORKING_REGISTER_N; i++) begin
      default_working_register_file[i*DATA_W +: DATA_W] = regs[i];
    end
  end
endmodule

// file: oad_decode_tb_top.sv
module oad_decode_tb_top
  import oad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic sys_rst;
  oad_req_t req;
  logic [DEFAULT_WORKING_REGISTER_N*DATA_W-1:0] default_working_register_file;
  oad_resp_t resp;
  logic ptr_we;
  logic [WIDX_W-1:0] ptr_idx;
  logic [DATA_W-1:0] ptr_value;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] w [16];
  oad_decode i_oad_decode(.core_clk(core_clk), .sys_rst(sys_rst), .req(req), .default_working_register_file(default_working_register_file), .resp(resp),
    .ptr_we(ptr_we), .ptr_idx(ptr_idx), .ptr_value(ptr_value));
  oad_default_working_register_model i_oad_default_working_register_model(.core_clk(core_clk), .sys_rst(sys_rst), .ptr_we(ptr_we), .ptr_idx(ptr_idx),
    .ptr_value(ptr_value), .default_working_register_file(default_working_register_file));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
    end
  end
  // ***************
  // helpers
  // ***************
  task test_done;
    $display("checks %0d, errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk_w(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  task chk_b(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask
  function automatic oad_req_t mk(oad_class_t c, oad_mode_t sm, logic [3:0] ss, oad_mode_t dm, logic [3:0] ds);
    oad_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.cls = c;
    r.mode_allow = 8'hff;
    r.base_sel = 4'h1;
    r.literal = 10'h3ff;
    r.src_mode = sm;
    r.src_sel = ss;
    r.dst_mode = dm;
    r.dst_sel = ds;
    return r;
  endfunction
  task issue(input oad_req_t r);
    @(posedge core_clk);
    req <= r;
    @(posedge core_clk);
    req <= '0;
    #1;
    chk_b(resp.valid, 1'b1);
  endtask
  // ***************
  // scenarios
  // ***************
  task t_file;
    oad_req_t r;
    r = mk(OAD_CLS_FILE, OAD_DIRECT, 4'h0, OAD_DIRECT, 4'h0);
    r.near_addr = 13'h1abc;
    issue(r);
    chk_w(resp.op2_addr, 16'h1abc);
    chk_w(resp.op1, w[0]);
    chk_b(resp.res_to_mem, 1'b1);
    chk_w(resp.res_addr, 16'h1abc);
    r.near_addr = 13'h1fff;
    r.to_default_working_register = 1'b1;
    issue(r);
    chk_w(resp.op2_addr, 16'h1fff);
    chk_b(resp.res_to_mem, 1'b0);
    chk_w({12'h000, resp.res_reg}, {12'h000, WORKING_REGISTER_ZERO});
    r = mk(OAD_CLS_XFER, OAD_DIRECT, 4'h0, OAD_DIRECT, 4'h0);
    r.full_addr = 16'hfffe;
    issue(r);
    chk_w(resp.op2_addr, 16'hfffe);
    chk_b(resp.res_to_mem, 1'b1);
    chk_w(resp.res_addr, 16'hfffe);
  endtask
  task t_three;
    oad_req_t r;
    oad_mode_t m [4];
    logic [15:0] nv;
    m = '{OAD_PRE_INC, OAD_POST_INC, OAD_POST_DEC, OAD_PRE_DEC};
    for (int k = 0; k < 4; k++) begin
      r = mk(OAD_CLS_THREE, m[k], 4'h2, OAD_DIRECT, 4'h5);
      nv = (k < 2) ? w[2] + PTR_STEP : w[2] - PTR_STEP;
      issue(r);
      chk_b(resp.mode_error, 1'b0);
      chk_w(resp.op1, w[1]);
      chk_b(resp.op2_from_mem, 1'b1);
      chk_w(resp.op2_addr, (k == 0 || k == 3) ? nv : w[2]);
      chk_b(ptr_we, 1'b1);
      chk_w({12'h000, ptr_idx}, 16'h0002);
      chk_w(ptr_value, nv);
      chk_b(resp.res_to_mem, 1'b0);
      chk_w({12'h000, resp.res_reg}, 16'h0005);
      w[2] = nv;
    end
    issue(mk(OAD_CLS_THREE, OAD_INDIRECT, 4'h3, OAD_INDIRECT, 4'h4));
    chk_w(resp.op2_addr, w[3]);
    chk_b(ptr_we, 1'b0);
    chk_b(resp.res_to_mem, 1'b1);
    chk_w(resp.res_addr, w[4]);
    issue(mk(OAD_CLS_THREE, OAD_LIT5, 4'h0, OAD_DIRECT, 4'h5));
    chk_b(resp.op2_from_mem, 1'b0);
    chk_w(resp.op2_lit, 16'h001f);
    issue(mk(OAD_CLS_THREE, OAD_LIT10, 4'h0, OAD_DIRECT, 4'h5));
    chk_w(resp.op2_lit, 16'h03ff);
    issue(mk(OAD_CLS_THREE, OAD_DIRECT, 4'h7, OAD_DIRECT, 4'h5));
    chk_b(resp.op2_from_mem, 1'b0);
    chk_w(resp.op2_lit, w[7]);
    issue(mk(OAD_CLS_THREE, OAD_POST_INC, 4'h8, OAD_PRE_DEC, 4'h9));
    chk_w(resp.op2_addr, w[8]);
    chk_b(resp.res_to_mem, 1'b1);
    chk_w(resp.res_addr, w[9] - PTR_STEP);
    chk_w({12'h000, ptr_idx}, 16'h0009);
    chk_w(ptr_value, w[9] - PTR_STEP);
    w[9] = w[9] - PTR_STEP;
  endtask
  task t_refuse;
    oad_req_t r;
    r = mk(OAD_CLS_THREE, OAD_PRE_INC, 4'h2, OAD_DIRECT, 4'h5);
    r.mode_allow = 8'hef;
    issue(r);
    chk_b(resp.mode_error, 1'b1);
    chk_b(ptr_we, 1'b0);
    r.mode_allow = 8'hff;
    r.mac_class = 1'b1;
    r.dst_mode = OAD_INDIRECT;
    issue(r);
    chk_b(resp.mode_error, 1'b1);
    chk_b(resp.res_to_mem, 1'b0);
    chk_b(ptr_we, 1'b0);
    r.mac_class = 1'b0;
    r.mode_allow = 8'hfd;
    issue(r);
    chk_b(resp.mode_error, 1'b1);
    chk_b(resp.res_to_mem, 1'b0);
    r = mk(OAD_CLS_PRODUCT, OAD_DIRECT, 4'h6, OAD_DIRECT, 4'h6);
    r.dst_pair = 1'b1;
    issue(r);
    chk_b(resp.res_pair, 1'b1);
    chk_w({12'h000, resp.res_reg}, 16'h0006);
  endtask
  task t_reset;
    oad_req_t r;
    r = mk(OAD_CLS_THREE, OAD_PRE_INC, 4'h2, OAD_DIRECT, 4'h5);
    @(posedge core_clk);
    req <= r;
    sys_rst <= 1'b1;
    @(posedge core_clk);
    req <= '0;
    #1;
    chk_b(resp.valid, 1'b0);
    chk_b(ptr_we, 1'b0);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      w[i] = 16'h1000 + 16'(i) * 16'h0100;
    end
    issue(r);
    chk_w(resp.op2_addr, w[2] + PTR_STEP);
    chk_w(ptr_value, w[2] + PTR_STEP);
  endtask
  initial begin
    req = '0;
    sys_rst = 1'b1;
    for (int i = 0; i < 16; i++) begin
      w[i] = 16'h1000 + 16'(i) * 16'h0100;
    end
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_file();
    t_three();
    t_refuse();
    t_reset();
    test_done();
  end
endmodule
